// *** verilog/sdram_activate_read_access.sv ***
// Command decoder, mode registers and read strobe/data serializer of an SDRAM die.
// Assumes the link clock, chip select and command bits arrive asynchronously and
// that an array model answers column reads in order through arr_valid/arr_data.
`timescale 1ns/100ps

// Behaviour
// - Bank mask bit n blocks bank n refresh
// - Eight segment mask bits, zero keeps refresh
// - Segment n means top three row bits n
// - Reads at 20h/28h return training patterns
// - Write to 3Fh resets; never read it
// - Activate decode: bank and row captured
// - Column decode: bit two selects read/write
// - Column from rising bits 5-6, falling 1-9
// - Read data after read latency edges
// - Strobe preamble low, data edge aligned
// - Seamless reads give gapless data
module sdram_activate_read_access #(
    parameter int          DQ_W      = 16,
    parameter int          BANKS     = 8,
    parameter int          ROW_W     = 15,
    parameter bit          SEG_EN    = 1'b1,
    parameter logic [15:0] PAT_A     = 16'h5555,  // Arbitrary training pattern
    parameter logic [15:0] PAT_B     = 16'h3C3C   // Arbitrary training pattern
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      ck_t,
    input  wire logic                      cs_n,
    input  wire logic [9:0]                ca,
    output logic [DQ_W-1:0]                dq_out,
    output logic                           dq_oe,
    output logic                           dqs_t,
    output logic                           dqs_c,
    output logic                           dqs_oe,
    output logic                           act_valid,
    output sdram_cmd_pkg::cmd_s            act_cmd,
    output logic                           rd_valid,
    output logic                           wr_valid,
    output sdram_cmd_pkg::cmd_s            col_cmd,
    input  wire logic                      arr_valid,
    input  wire logic [DQ_W-1:0]           arr_data,
    output logic                           arr_ready,
    input  wire logic [ROW_W-1:0]          refresh_row,
    output logic [7:0]                     bank_refresh_block,
    output logic                           row_refresh_block,
    output logic [7:0]                     bank_open,
    output logic                           dev_reset,
    output logic                           underrun
);
    import sdram_cmd_pkg::*;

    if (!(BANKS == 4 || BANKS == 8) || ROW_W > ROW_BITS || ROW_W < SEG_BITS
        || DQ_W > 16 || DQ_W < 8) begin : g_bad_param
        $error("sdram_activate_read_access: unsupported parameter values");
    end

    localparam logic [7:0] BANK_USED = (BANKS == 8) ? 8'hFF : 8'h0F;

    function automatic logic [4:0] last_beat(input logic [2:0] code);
        unique case (code)
            3'h3:    last_beat = 5'h07;
            3'h4:    last_beat = 5'h0F;
            default: last_beat = 5'h03;
        endcase
    endfunction

    // Two-flop synchroniser for {ck, cs_n, ca}
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end else begin
            sync1_reg <= {ck_t, cs_n, ca};
            sync2_reg <= sync1_reg;
        end
    end

    ctl_s       st_reg;
    ctl_s       st_next;
    logic       rise;
    logic       fall;
    logic [9:0] ca_s;
    logic [7:0] ma;
    logic [7:0] op;
    logic       mrw_hit;
    logic       act_hit;
    logic       col_hit;
    logic       beat;
    logic       beat_mrr;

    assign ca_s = sync2_reg[9:0];
    assign rise = sync2_reg[11] & ~st_reg.ck_d;
    assign fall = ~sync2_reg[11] & st_reg.ck_d;
    assign ma   = {ca_s[1:0], st_reg.ca_r[9:4]};
    assign op   = ca_s[9:2];

    always_comb begin
        st_next         = st_reg;
        st_next.ck_d    = sync2_reg[11];
        st_next.act_v   = 1'b0;
        st_next.rd_v    = 1'b0;
        st_next.wr_v    = 1'b0;
        st_next.reset_p = 1'b0;
        mrw_hit         = 1'b0;
        act_hit         = 1'b0;
        col_hit         = 1'b0;
        beat            = 1'b0;
        beat_mrr        = st_reg.burst_mrr;
        if (rise) begin
            st_next.ca_r     = ca_s;
            st_next.cs_r     = sync2_reg[10];
            st_next.rd_pipe  = {st_reg.rd_pipe[6:0], st_reg.rd_pend};
            st_next.mrr_pipe = {st_reg.mrr_pipe[6:0], st_reg.mrr_pend};
            st_next.rd_pend  = 1'b0;
            st_next.mrr_pend = 1'b0;
            if (st_reg.rd_pipe[st_reg.lat_code[2:0]]) begin
                // Latency reached: a new burst also cuts a running one
                st_next.state     = RD_BURST;
                st_next.burst_mrr = st_reg.mrr_pipe[st_reg.lat_code[2:0]];
                st_next.beats     = st_next.burst_mrr ? MRR_BEATS
                                                      : last_beat(st_reg.bl_code);
                st_next.dqs       = 1'b1;
                st_next.oe        = 1'b1;
                beat              = 1'b1;
                beat_mrr          = st_next.burst_mrr;
            end else if (st_reg.state == RD_BURST && st_reg.beats != 5'h00) begin
                st_next.dqs   = 1'b1;
                st_next.beats = st_reg.beats - 5'h01;
                beat          = 1'b1;
            end else if (st_reg.rd_pipe[st_reg.lat_code[2:0] - 3'h1]) begin
                st_next.state = RD_PRE;
                st_next.oe    = 1'b1;
                st_next.dqs   = 1'b0;
            end else if (st_reg.state == RD_BURST) begin
                st_next.state = RD_IDLE;
                st_next.oe    = 1'b0;
            end
        end
        if (fall) begin
            if (st_reg.state == RD_BURST && st_reg.beats != 5'h00) begin
                st_next.dqs   = 1'b0;
                st_next.beats = st_reg.beats - 5'h01;
                beat          = 1'b1;
            end
            if (!st_reg.cs_r) begin
                if (st_reg.ca_r[1:0] == CMD_ACT) begin
                    act_hit                       = 1'b1;
                    st_next.act_v                 = 1'b1;
                    st_next.act_cmd.bank          = st_reg.ca_r[9:7];
                    st_next.act_cmd.row           = {st_reg.ca_r[6:2], ca_s};
                    st_next.act_cmd.col           = '0;
                    st_next.bank_open[st_reg.ca_r[9:7]] = 1'b1;
                end else if (st_reg.ca_r[1:0] == CMD_COL) begin
                    col_hit              = 1'b1;
                    st_next.col_cmd.bank = st_reg.ca_r[9:7];
                    st_next.col_cmd.row  = '0;
                    st_next.col_cmd.col  = {st_reg.ca_r[6:5], ca_s[9:1], 1'b0};
                    st_next.rd_v         = st_reg.ca_r[2];
                    st_next.wr_v         = ~st_reg.ca_r[2];
                    st_next.rd_pend      = st_reg.ca_r[2];
                end else if (st_reg.ca_r[3:0] == CMD_PRE) begin
                    if (st_reg.ca_r[4]) begin
                        st_next.bank_open = '0;
                    end else begin
                        st_next.bank_open[st_reg.ca_r[9:7]] = 1'b0;
                    end
                end else if (st_reg.ca_r[3:0] == CMD_MRR) begin
                    // Only the pattern addresses answer; others stay silent
                    if (ma == MA_PATTERN_A || ma == MA_PATTERN_B) begin
                        st_next.rd_pend   = 1'b1;
                        st_next.mrr_pend  = 1'b1;
                        st_next.mrr_sel_b = (ma == MA_PATTERN_B);
                    end
                end else if (st_reg.ca_r[3:0] == CMD_MRW) begin
                    mrw_hit = 1'b1;
                    unique case (ma)
                        MA_BANK_MASK: st_next.bank_mask = op & BANK_USED;
                        MA_SEG_MASK:  st_next.seg_mask  = op;
                        MA_BURST: begin
                            if (op[2:0] inside {3'h2, 3'h3, 3'h4}) begin
                                st_next.bl_code = op[2:0];
                            end
                        end
                        MA_LATENCY: begin
                            if (op[3:0] >= LAT_CODE_MIN && op[3:0] <= LAT_CODE_MAX) begin
                                st_next.lat_code = op[3:0];
                            end
                        end
                        MA_RESET: begin
                            st_next         = CTL_RST;
                            st_next.ck_d    = sync2_reg[11];
                            st_next.reset_p = 1'b1;
                        end
                        // Do-not-use and reserved addresses are ignored
                        default: st_next.reset_p = 1'b0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= CTL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Two-entry buffer between the array and the serializer
    logic [DQ_W-1:0] mem_reg [2];
    logic [DQ_W-1:0] mem_next [2];
    logic            wp_reg;
    logic            wp_next;
    logic            rp_reg;
    logic            rp_next;
    logic [1:0]      cnt_reg;
    logic [1:0]      cnt_next;
    logic [DQ_W-1:0] dq_reg;
    logic [DQ_W-1:0] dq_next;
    logic            und_reg;
    logic            und_next;
    logic            push;
    logic            pop;

    assign arr_ready = (cnt_reg != 2'h2);
    assign push      = arr_valid & arr_ready;
    assign pop       = beat & ~beat_mrr & (cnt_reg != 2'h0);

    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        dq_next  = dq_reg;
        und_next = und_reg & ~st_next.reset_p;
        if (push) begin
            mem_next[wp_reg] = arr_data;
            wp_next          = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        if (beat) begin
            if (beat_mrr) begin
                dq_next = st_next.mrr_sel_b ? PAT_B[DQ_W-1:0] : PAT_A[DQ_W-1:0];
            end else if (cnt_reg != 2'h0) begin
                dq_next = mem_reg[rp_reg];
            end else begin
                dq_next  = '0;
                und_next = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_reg <= '{default: '0};
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
            dq_reg  <= '0;
            und_reg <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            dq_reg  <= dq_next;
            und_reg <= und_next;
        end
    end

    assign dq_out             = dq_reg;
    assign dq_oe              = st_reg.state == RD_BURST;
    assign dqs_t              = st_reg.dqs;
    assign dqs_c              = ~st_reg.dqs;
    assign dqs_oe             = st_reg.oe;
    assign act_valid          = st_reg.act_v;
    assign act_cmd            = st_reg.act_cmd;
    assign rd_valid           = st_reg.rd_v;
    assign wr_valid           = st_reg.wr_v;
    assign col_cmd            = st_reg.col_cmd;
    assign bank_refresh_block = st_reg.bank_mask;
    assign row_refresh_block  = SEG_EN
                              & st_reg.seg_mask[refresh_row[ROW_W-1 -: SEG_BITS]];
    assign bank_open          = st_reg.bank_open;
    assign dev_reset          = st_reg.reset_p;
    assign underrun           = und_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_burst_start;
        rise && st_reg.rd_pipe[st_reg.lat_code[2:0]];
    endsequence

    a_bank_mask_write: assert property (mrw_hit && ma == MA_BANK_MASK |=>
        bank_refresh_block == ($past(op) & BANK_USED))
        else $error("bank mask not taken from write");
    a_seg_mask_write: assert property (mrw_hit && ma == MA_SEG_MASK |=>
        st_reg.seg_mask == $past(op))
        else $error("segment mask not taken from write");
    a_seg_row_map: assert property (st_reg.seg_mask == 8'h00 |->
        !row_refresh_block)
        else $error("row blocked with empty segment mask");
    a_pattern_read: assert property (st_reg.state == RD_BURST && st_reg.burst_mrr
        |-> dq_out == (st_reg.mrr_sel_b ? PAT_B[DQ_W-1:0] : PAT_A[DQ_W-1:0]))
        else $error("pattern read returned wrong word");
    a_reset_pulse: assert property (mrw_hit && ma == MA_RESET |=>
        dev_reset && st_reg.bank_mask == 8'h00 ##1 !dev_reset)
        else $error("reset write did not pulse reset");
    a_act_decode: assert property (act_hit |=> act_valid
        && act_cmd.bank == $past(st_reg.ca_r[9:7]) && bank_open[act_cmd.bank])
        else $error("activate not decoded");
    a_col_decode: assert property (col_hit |=> (rd_valid != wr_valid)
        && rd_valid == $past(st_reg.ca_r[2])
        && col_cmd.col[8:1] == $past(ca_s[8:1]))
        else $error("column command not decoded");
    a_read_latency: assert property (s_burst_start |=> dqs_t && dqs_oe
        && st_reg.state == RD_BURST)
        else $error("burst did not start at read latency");
    a_strobe_pre: assert property ($rose(dqs_oe) |-> !dqs_t [*8])
        else $error("strobe preamble too short");
endmodule

// *** pkg/sdram_cmd_pkg.sv ***
// Constants, command encodings and carriers for the SDRAM command decoder.
// Assumes the command bus is sampled in the core clock domain after synchronising.
package sdram_cmd_pkg;

    // Mode register addresses
    localparam logic [7:0] MA_BURST      = 8'h01;
    localparam logic [7:0] MA_LATENCY    = 8'h02;
    localparam logic [7:0] MA_BANK_MASK  = 8'h10;
    localparam logic [7:0] MA_SEG_MASK   = 8'h11;
    localparam logic [7:0] MA_PATTERN_A  = 8'h20;
    localparam logic [7:0] MA_PATTERN_B  = 8'h28;
    localparam logic [7:0] MA_RESET      = 8'h3F;
    localparam logic [7:0] MA_DNU_LOW    = 8'h7F;
    localparam logic [7:0] MA_DNU_MID    = 8'hBF;
    localparam logic [7:0] MA_DNU_HIGH   = 8'hFF;

    // Command codes on cmd bits 1..0 (ACT, COL) or 3..0 (MRW, MRR, PRE) at the rising edge
    localparam logic [1:0] CMD_ACT       = 2'h2;
    localparam logic [1:0] CMD_COL       = 2'h1;
    localparam logic [3:0] CMD_MRW       = 4'h0;
    localparam logic [3:0] CMD_MRR       = 4'h8;
    localparam logic [3:0] CMD_PRE       = 4'hB;

    // Values after reset, latency code limits, pattern beat count and widths
    localparam logic [3:0] LAT_CODE_RST  = 4'h1;
    localparam logic [3:0] LAT_CODE_MIN  = 4'h1;
    localparam logic [3:0] LAT_CODE_MAX  = 4'h6;
    localparam logic [2:0] BL_CODE_RST   = 3'h2;
    localparam logic [4:0] MRR_BEATS     = 5'h03;
    localparam logic [11:0] SYNC_RST     = 12'h400;
    localparam int          ROW_BITS     = 15;
    localparam int          SEG_BITS     = 3;

    typedef enum logic [1:0] {RD_IDLE, RD_PRE, RD_BURST} rd_state_e;

    typedef struct packed {
        logic [2:0]          bank;
        logic [ROW_BITS-1:0] row;
        logic [11:0]         col;
    } cmd_s;

    typedef struct packed {
        logic [9:0] ca_r;
        logic       cs_r;
        logic       ck_d;
        logic [7:0] bank_mask;
        logic [7:0] seg_mask;
        logic [7:0] bank_open;
        logic [3:0] lat_code;
        logic [2:0] bl_code;
        logic       rd_pend;
        logic       mrr_pend;
        logic       mrr_sel_b;
        logic [7:0] rd_pipe;
        logic [7:0] mrr_pipe;
        rd_state_e  state;
        logic [4:0] beats;
        logic       burst_mrr;
        logic       dqs;
        logic       oe;
        logic       act_v;
        logic       rd_v;
        logic       wr_v;
        logic       reset_p;
        cmd_s       act_cmd;
        cmd_s       col_cmd;
    } ctl_s;

    localparam ctl_s CTL_RST = '{lat_code: LAT_CODE_RST, bl_code: BL_CODE_RST,
                                 state: RD_IDLE, default: '0};

endpackage

// *** dv/sdram_host_model.sv ***
// Host-side model: free-running link clock and command/address bus.
// Assumes the bench calls send() once per command, one command at a time.
`timescale 1ns/100ps
module sdram_host_model
    import sdram_cmd_pkg::*;
(
    output logic       ck_t,
    output logic       cs_n,
    output logic [9:0] ca
);
    localparam int ACT_GAP = 3;
    localparam int RCD_CK  = 3;
    localparam int RAS_CK  = 4;
    localparam int RC_CK   = 7;
    localparam int RPPB_CK = 3;
    localparam int RPAB_CK = 4;
    localparam int CK_NS   = 160;
    localparam int FAW_NS  = 1000;
    localparam int FAW_CK  = (FAW_NS + CK_NS - 1) / CK_NS;
    int last_act    = -100;
    int last_pre    = -100;
    int act_hist[4] = '{default: -100};
    int bank_act[8] = '{default: -100};
    bit pre_all     = 1'b0;
    int ck_n        = 0;

    initial begin
        ck_t = 1'b0;
        cs_n = 1'b1;
        ca   = 10'h000;
    end
    always #80 ck_t = ~ck_t;
    always @(posedge ck_t) ck_n <= ck_n + 1;

    task automatic send(input logic [9:0] car, input logic [9:0] caf);
        if (car[3:0] == 4'h8 && {caf[1:0], car[9:4]} == MA_RESET) begin
            return;
        end
        if (car[2:0] == 3'h0
            && {caf[1:0], car[9:4]} inside {MA_DNU_LOW, MA_DNU_MID, MA_DNU_HIGH}) begin
            return;
        end
        if (car[1:0] == CMD_ACT) begin
            // Other banks spaced by ACT_GAP, same bank by RC_CK, four per window
            while (ck_n - last_act < ACT_GAP
                   || ck_n - bank_act[car[9:7]] < RC_CK
                   || ck_n - act_hist[0] < FAW_CK
                   || ck_n - last_pre < (pre_all ? RPAB_CK : RPPB_CK))
                @(posedge ck_t);
        end
        if (car[3:0] == CMD_PRE) begin
            while (ck_n - last_act < RAS_CK) @(posedge ck_t);
        end
        if (car[1:0] == CMD_COL) begin
            while (ck_n - last_act < RCD_CK) @(posedge ck_t);
        end
        @(negedge ck_t);
        #40;
        cs_n = 1'b0;
        ca   = car;
        @(posedge ck_t);
        #40;
        if (car[1:0] == CMD_ACT) begin
            last_act           = ck_n;
            bank_act[car[9:7]] = ck_n;
            act_hist           = '{act_hist[1], act_hist[2], act_hist[3], ck_n};
        end
        if (car[3:0] == CMD_PRE) begin
            last_pre = ck_n;
            pre_all  = car[4];
        end
        ca = caf;
        @(negedge ck_t);
        #40;
        cs_n = 1'b1;
        ca   = ~caf;
    endtask
endmodule

// *** dv/sdram_activate_read_access_tb.sv ***
// Self-checking bench for the SDRAM command decoder and read serializer.
// Assumes the host model drives the command bus; the bench feeds array words.
`timescale 1ns/100ps
module sdram_activate_read_access_tb;
    import sdram_cmd_pkg::*;
    localparam logic [15:0] PA = 16'hA5C3;  // Arbitrary pattern
    localparam logic [15:0] PB = 16'h0FF0;  // Arbitrary pattern
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ck_t, cs_n, dq_oe, dqs_t, dqs_c, dqs_oe, act_valid, rd_valid, wr_valid;
    logic [9:0] ca;
    logic [15:0] dq_out, arr_data;
    logic arr_valid = 1'b0;
    logic arr_ready, row_refresh_block, dev_reset, underrun;
    logic [14:0] refresh_row = '0;
    logic [7:0] bank_refresh_block, bank_open, op, exp_open;
    cmd_s act_cmd, col_cmd;
    logic [31:0] exp_act[$], exp_col[$], exp_dq[$], exp_run[$];
    int failures = 0;
    int check_count = 0;
    int seed = 32'he2b2;
    int feed_cnt = 0;
    int run = 0;
    int lat = 0;
    int pre = 0;
    int cyc = 0;
    bit meas = 0;
    bit lat_on = 0;
    bit oe_prev = 0;
    bit took = 0;
    int rst_seen = 0;
    int exp_lat = 50;
    logic dqs_prev = 1'b0;

    always #4 core_clk = ~core_clk;

    sdram_host_model host (.ck_t(ck_t), .cs_n(cs_n), .ca(ca));

    sdram_activate_read_access #(.PAT_A(PA), .PAT_B(PB)) DUT (
        .core_clk(core_clk), .rst(rst), .ck_t(ck_t), .cs_n(cs_n), .ca(ca),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_t(dqs_t), .dqs_c(dqs_c), .dqs_oe(dqs_oe),
        .act_valid(act_valid), .act_cmd(act_cmd), .rd_valid(rd_valid),
        .wr_valid(wr_valid), .col_cmd(col_cmd), .arr_valid(arr_valid),
        .arr_data(arr_data), .arr_ready(arr_ready), .refresh_row(refresh_row),
        .bank_refresh_block(bank_refresh_block), .row_refresh_block(row_refresh_block),
        .bank_open(bank_open), .dev_reset(dev_reset), .underrun(underrun));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic mr(input logic rd, input logic [7:0] a, input logic [7:0] v);
        host.send({a[5:0], rd, 3'b000}, {v, a[7:6]});
        idle(4);
    endtask

    task automatic col(input logic rd, input logic [2:0] b, input logic [11:0] c);
        exp_col.push_back({1'b0, rd, b, 15'h0, c[11:1], 1'b0});
        host.send({b, c[11:10], 2'b00, rd, 2'b01}, {c[9:1], 1'b0});
    endtask

    task automatic drain;
        for (int k = 0; k < 600 && (exp_run.size() != 0 || oe_prev); k++) idle(1);
    endtask

    // Array feeder: a word stands until the buffer has taken it
    always @(negedge core_clk) begin
        if (!arr_valid || took) arr_data = $random(seed);
        arr_valid = feed_cnt > 0;
    end

    // Output monitor: compares each result with the oldest note
    always @(posedge core_clk) begin
        if (++cyc == 20000) begin
            failures++;
            summarize();
        end
        took = arr_valid && arr_ready === 1'b1;
        if (dev_reset === 1'b1) rst_seen++;
        if (took) begin
            exp_dq.push_back(arr_data);
            feed_cnt--;
        end
        if (act_valid === 1'b1) check(act_cmd, exp_act.size() ? exp_act.pop_front() : 'x);
        if (rd_valid === 1'b1 || wr_valid === 1'b1)
            check({rd_valid, col_cmd}, exp_col.size() ? exp_col.pop_front() : 'x);
        if (rd_valid === 1'b1 && meas) begin
            lat_on = 1;
            meas = 0;
            lat = 0;
        end else if (lat_on) lat++;
        if (dqs_oe === 1'b1 && dq_oe !== 1'b1) pre++;
        if (dq_oe === 1'b1 && !oe_prev) begin
            check(pre >= 19 && pre <= 21, 1'b1);
            pre = 0;
            if (lat_on) check(lat >= exp_lat - 2 && lat <= exp_lat + 2, 1'b1);
            lat_on = 0;
        end
        if (dq_oe === 1'b1 && (dqs_t !== dqs_prev || !oe_prev)) begin
            check(dq_out, exp_dq.size() ? exp_dq.pop_front() : 'x);
            run++;
        end
        if (oe_prev && dq_oe !== 1'b1) begin
            check(run, exp_run.size() ? exp_run.pop_front() : 'x);
            run = 0;
        end
        dqs_prev = dqs_t;
        oe_prev = dq_oe === 1'b1;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        idle(1);
        rst = 1'b0;
        check({bank_open, bank_refresh_block, dqs_c, arr_ready}, 18'h00003);
        op = $random(seed);
        mr(1'b0, MA_BANK_MASK, op);
        check(bank_refresh_block, op);
        mr(1'b0, 8'h12, ~op);
        check(bank_refresh_block, op);
        op = $random(seed);
        mr(1'b0, MA_SEG_MASK, op);
        for (int n = 0; n < 8; n++) begin
            refresh_row = {n[2:0], 12'(int'($random(seed)))};
            idle(1);
            check(row_refresh_block, op[n]);
        end
        exp_open = '0;
        for (int i = 0; i < 5; i++) begin
            logic [14:0] r;
            r = $random(seed);
            exp_open[i] = 1'b1;
            exp_act.push_back({2'b00, 3'(i), r, 12'h000});
            host.send({3'(i), r[14:10], 2'b10}, r[9:0]);
        end
        idle(6);
        check(bank_open, exp_open);
        feed_cnt = 2;
        idle(10);
        check(arr_ready, 1'b0);
        feed_cnt = 4;
        idle(10);
        exp_run.push_back(4);
        meas = 1;
        col(1'b1, 3'd1, 12'($random(seed)));
        drain();
        feed_cnt = 8;
        exp_run.push_back(8);
        col(1'b1, 3'd2, 12'($random(seed)));
        col(1'b1, 3'd0, 12'($random(seed)));
        drain();
        col(1'b0, 3'd3, 12'($random(seed)));
        for (int p = 0; p < 2; p++) begin
            // Pattern beats leave the buffered array words in place
            repeat (4) exp_dq.push_front(p ? PB : PA);
            exp_run.push_back(4);
            mr(1'b1, p ? MA_PATTERN_B : MA_PATTERN_A, 8'h00);
            drain();
        end
        // Two buffered words, then beats with nothing to send
        check(underrun, 1'b0);
        repeat (2) exp_dq.push_back(16'h0000);
        exp_run.push_back(4);
        col(1'b1, 3'h4, 12'($random(seed)));
        drain();
        check(underrun, 1'b1);
        // Latency code 2 and burst code 3: four link clocks, eight beats
        mr(1'b0, MA_LATENCY, 8'h02);
        mr(1'b0, MA_BURST, 8'h03);
        feed_cnt = 8;
        exp_run.push_back(8);
        exp_lat = 70;
        meas = 1;
        col(1'b1, 3'h0, 12'($random(seed)));
        drain();
        host.send({3'h1, 2'b00, 1'b0, CMD_PRE}, 10'h000);
        idle(6);
        check(bank_open, 8'h1D);
        exp_act.push_back({2'b00, 3'h1, 15'h0000, 12'h000});
        host.send({3'h1, 5'h00, 2'b10}, 10'h000);
        idle(6);
        check(bank_open, 8'h1F);
        host.send({3'h0, 2'b00, 1'b1, CMD_PRE}, 10'h000);
        idle(6);
        check(bank_open, 8'h00);
        mr(1'b1, MA_RESET, 8'h00);
        host.send({MA_RESET[5:0], 4'h0}, {8'($random(seed)), MA_RESET[7:6]});
        idle(4);
        check(rst_seen, 1);
        check({bank_open, bank_refresh_block, underrun}, 17'h0_0000);
        check(exp_act.size() + exp_col.size() + exp_dq.size() + exp_run.size(), 0);
        summarize();
    end
endmodule
